// file: address_table_cfg_pkg.sv
package address_table_cfg_pkg;

  // Bus geometry
  localparam int          ADDR_WIDTH       = 10;
  localparam int          DATA_WIDTH       = 32;
  localparam int          WORD_SHIFT       = 2;
  localparam int          STRB_WIDTH       = DATA_WIDTH / 8;

  // Register indices; byte address is the index times four
  localparam logic [7:0]  IDX_CONFIG       = 8'h00;
  localparam logic [7:0]  IDX_TRAP_FIRST   = 8'h04;
  localparam logic [7:0]  IDX_TRAP_LAST    = 8'h09;
  localparam logic [7:0]  IDX_AGE_PERIOD   = 8'he0;
  localparam logic [7:0]  IDX_TRAP_COUNT   = 8'he1;
  localparam logic [7:0]  IDX_PAGE         = 8'hff;
  localparam logic [7:0]  PAGE_THIS        = 8'h04;
  localparam logic [7:0]  PAGE_RESET       = 8'h00;

  // Configuration byte layout
  localparam int          CFG_BYPASS_BIT   = 0;
  localparam int          CFG_FIXED_ONE_BIT = 1;
  localparam int          CFG_SPEEDUP_BIT  = 2;
  localparam logic [7:0]  CFG_WRITE_MASK   = 8'h05;
  localparam logic [7:0]  CFG_RESET        = 8'h02;

  // Trap address
  localparam int          TRAP_BYTES       = 6;
  localparam logic [47:0] TRAP_RESET       = 48'h0180c2000000;
  localparam int          TRAP_COUNT_WIDTH = 16;

  // Aging
  localparam int          AGE_SPEEDUP_SHIFT = 7;
  localparam int          AGE_PERIOD_MS    = 1000;
  localparam int          CLK_PERIOD_NS    = 20;
  localparam int          AGE_PERIOD_CYCLES =
    AGE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

  // Responses
  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESPOND = 2'b10
  } wr_state_type;

  typedef enum logic [1:0] {
    RD_IDLE    = 2'b01,
    RD_RESPOND = 2'b10
  } rd_state_type;

endpackage

// file: address_table_global_config.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Speed-up bit set makes aging run 128 times faster.
// - Speed-up bit clear keeps aging at its normal, unscaled rate.
// - Hash bypass bit set selects direct-mapped table placement.
// - Hash bypass bit is zero after reset, so hashing is active.
// - Frames whose destination equals the trap address go to management.
// - Trap address resets to the standard bridge group multicast address.
// - Software may rewrite the trap address; matching then uses it.
// - Config byte at index 00h, trap address at indices 04h to 09h.
// - Page register at index FFh in every page selects this page.
module address_table_global_config
  import address_table_cfg_pkg::*;
#(
  parameter logic [31:0] AGE_PERIOD = 32'(AGE_PERIOD_CYCLES)
)
(
  input  wire logic                  REF_CLK,
  input  wire logic                  RST,
  input  wire logic [ADDR_WIDTH-1:0] AWADDR,
  input  wire logic                  AWVALID,
  output logic                       AWREADY,
  input  wire logic [DATA_WIDTH-1:0] WDATA,
  input  wire logic [STRB_WIDTH-1:0] WSTRB,
  input  wire logic                  WVALID,
  output logic                       WREADY,
  output logic [1:0]                 BRESP,
  output logic                       BVALID,
  input  wire logic                  BREADY,
  input  wire logic [ADDR_WIDTH-1:0] ARADDR,
  input  wire logic                  ARVALID,
  output logic                       ARREADY,
  output logic [DATA_WIDTH-1:0]      RDATA,
  output logic [1:0]                 RRESP,
  output logic                       RVALID,
  input  wire logic                  RREADY,
  input  wire logic                  FRAME_DA_VALID,
  input  wire logic [47:0]           FRAME_DA,
  output logic                       TRAP_VALID,
  output logic                       TRAP_HIT,
  output logic                       AGE_TICK,
  output logic                       AGE_SPEEDUP,
  output logic                       HASH_BYPASS
);

  wr_state_type                 wr_state;
  rd_state_type                 rd_state;
  logic [ADDR_WIDTH-1:0]        aw_addr;
  logic                         aw_held;
  logic [DATA_WIDTH-1:0]        w_data;
  logic [STRB_WIDTH-1:0]        w_strb;
  logic                         w_held;
  logic                         aw_take;
  logic                         w_take;
  logic                         ar_take;
  logic                         do_write;
  logic [7:0]                   wr_idx;
  logic [7:0]                   ar_idx;
  logic [7:0]                   config_byte;
  logic [47:0]                  trap_address;
  logic [7:0]                   page;
  logic [31:0]                  age_period;
  logic [TRAP_COUNT_WIDTH-1:0]  trap_count;
  logic                         hit_raw;

  function automatic logic [7:0] word_index(logic [ADDR_WIDTH-1:0] a);
    return a[WORD_SHIFT +: 8];
  endfunction

  // The page register answers in every page; the rest only in ours
  function automatic logic is_mapped(logic [7:0] idx, logic [7:0] pg);
    if (idx == IDX_PAGE)
      return 1'b1;
    else if (pg != PAGE_THIS)
      return 1'b0;
    else if (idx == IDX_CONFIG)
      return 1'b1;
    else if (idx >= IDX_TRAP_FIRST && idx <= IDX_TRAP_LAST)
      return 1'b1;
    else if (idx == IDX_AGE_PERIOD || idx == IDX_TRAP_COUNT)
      return 1'b1;
    else
      return 1'b0;
  endfunction

  function automatic logic [31:0] read_word(logic [7:0] idx);
    logic [7:0] off;
    off = idx - IDX_TRAP_FIRST;
    if (idx == IDX_PAGE)
      return {24'h0, page};
    else if (idx == IDX_CONFIG)
      return {24'h0, config_byte};
    else if (idx >= IDX_TRAP_FIRST && idx <= IDX_TRAP_LAST)
      return {24'h0, trap_address[{off[2:0], 3'b000} +: 8]};
    else if (idx == IDX_AGE_PERIOD)
      return age_period;
    else if (idx == IDX_TRAP_COUNT)
      return {{(32 - TRAP_COUNT_WIDTH){1'b0}}, trap_count};
    else
      return 32'h0;
  endfunction

  function automatic logic [31:0] merge_strb(logic [31:0] old,
                                             logic [31:0] data,
                                             logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < STRB_WIDTH; b++) begin
      if (strb[b])
        res[8*b +: 8] = data[8*b +: 8];
    end
    return res;
  endfunction

  assign aw_take  = AWVALID && AWREADY;
  assign w_take   = WVALID && WREADY;
  assign ar_take  = ARVALID && ARREADY;
  assign do_write = aw_held && w_held && wr_state == WR_COLLECT;
  assign wr_idx   = word_index(aw_addr);
  assign ar_idx   = word_index(ARADDR);

  // Write channels: address and data are taken in either order
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wr_state <= WR_COLLECT;
      AWREADY  <= 1'b0;
      WREADY   <= 1'b0;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= '0;
      w_data   <= '0;
      w_strb   <= '0;
      BVALID   <= 1'b0;
      BRESP    <= RESP_OKAY;
    end else begin
      case (wr_state)
        WR_COLLECT: begin
          if (aw_take) begin
            aw_addr <= AWADDR;
            aw_held <= 1'b1;
          end
          if (w_take) begin
            w_data <= WDATA;
            w_strb <= WSTRB;
            w_held <= 1'b1;
          end
          AWREADY <= !(aw_held || aw_take);
          WREADY  <= !(w_held || w_take);
          if (do_write) begin
            wr_state <= WR_RESPOND;
            AWREADY  <= 1'b0;
            WREADY   <= 1'b0;
            BVALID   <= 1'b1;
            BRESP    <= is_mapped(wr_idx, page) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESPOND: begin
          if (BREADY) begin
            wr_state <= WR_COLLECT;
            BVALID   <= 1'b0;
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            AWREADY  <= 1'b1;
            WREADY   <= 1'b1;
          end
        end
        default: wr_state <= WR_COLLECT;
      endcase
    end
  end

  // Page register lives outside the page gate
  always_ff @(posedge REF_CLK) begin
    if (RST)
      page <= PAGE_RESET;
    else if (do_write && wr_idx == IDX_PAGE && w_strb[0])
      page <= w_data[7:0];
  end

  // Only the writable bits move; bit 1 is a constant one
  always_ff @(posedge REF_CLK) begin
    if (RST)
      config_byte <= CFG_RESET;
    else if (do_write && page == PAGE_THIS && wr_idx == IDX_CONFIG
             && w_strb[0])
      config_byte <= (config_byte & ~CFG_WRITE_MASK)
                   | (w_data[7:0] & CFG_WRITE_MASK);
  end

  // One byte lane per index; a partial update of the address is
  // visible to the matcher at once, so software should write all six
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      trap_address <= TRAP_RESET;
    end else if (do_write && page == PAGE_THIS && w_strb[0]) begin
      for (int b = 0; b < TRAP_BYTES; b++) begin
        if (wr_idx == IDX_TRAP_FIRST + 8'(b))
          trap_address[8*b +: 8] <= w_data[7:0];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST)
      age_period <= AGE_PERIOD;
    else if (do_write && page == PAGE_THIS && wr_idx == IDX_AGE_PERIOD)
      age_period <= merge_strb(age_period, w_data, w_strb);
  end

  // Saturates rather than wraps so a busy link never looks idle
  always_ff @(posedge REF_CLK) begin
    if (RST)
      trap_count <= '0;
    else if (hit_raw && trap_count != '1)
      trap_count <= trap_count + 1'b1;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      AGE_SPEEDUP <= 1'b0;
      HASH_BYPASS <= 1'b0;
    end else begin
      AGE_SPEEDUP <= config_byte[CFG_SPEEDUP_BIT];
      HASH_BYPASS <= config_byte[CFG_BYPASS_BIT];
    end
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rd_state <= RD_IDLE;
      ARREADY  <= 1'b0;
      RVALID   <= 1'b0;
      RDATA    <= '0;
      RRESP    <= RESP_OKAY;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          ARREADY <= !ar_take;
          if (ar_take) begin
            rd_state <= RD_RESPOND;
            RVALID   <= 1'b1;
            if (is_mapped(ar_idx, page)) begin
              RDATA <= read_word(ar_idx);
              RRESP <= RESP_OKAY;
            end else begin
              RDATA <= '0;
              RRESP <= RESP_SLVERR;
            end
          end
        end
        RD_RESPOND: begin
          if (RREADY) begin
            rd_state <= RD_IDLE;
            RVALID   <= 1'b0;
            ARREADY  <= 1'b1;
          end
        end
        default: rd_state <= RD_IDLE;
      endcase
    end
  end

  age_tick_gen u_age (
    .clk     (REF_CLK),
    .rst     (RST),
    .period  (age_period),
    .speedup (config_byte[CFG_SPEEDUP_BIT]),
    .tick    (AGE_TICK)
  );

  trap_match u_trap (
    .clk          (REF_CLK),
    .rst          (RST),
    .da_valid     (FRAME_DA_VALID),
    .da           (FRAME_DA),
    .trap_address (trap_address),
    .result_valid (TRAP_VALID),
    .hit          (hit_raw)
  );

  assign TRAP_HIT = hit_raw;

  chk_bypass_reset: assert property (
    @(posedge REF_CLK) $fell(RST) |-> !HASH_BYPASS && !config_byte[0])
    else $error("hash bypass not clear after reset");

  chk_trap_reset: assert property (
    @(posedge REF_CLK) $fell(RST) |-> trap_address == TRAP_RESET)
    else $error("trap address reset value wrong");

  chk_bypass_write: assert property (
    @(posedge REF_CLK) disable iff (RST)
    do_write && page == PAGE_THIS && wr_idx == IDX_CONFIG && w_strb[0]
      |=> ##1 HASH_BYPASS == $past(w_data[CFG_BYPASS_BIT], 2))
    else $error("hash bypass does not follow write");

  chk_speedup_write: assert property (
    @(posedge REF_CLK) disable iff (RST)
    do_write && page == PAGE_THIS && wr_idx == IDX_CONFIG && w_strb[0]
      |=> ##1 AGE_SPEEDUP == $past(w_data[CFG_SPEEDUP_BIT], 2))
    else $error("speed-up bit does not follow write");

  chk_trap_write: assert property (
    @(posedge REF_CLK) disable iff (RST)
    do_write && page == PAGE_THIS && wr_idx == IDX_TRAP_LAST && w_strb[0]
      |=> trap_address[47:40] == $past(w_data[7:0]))
    else $error("trap address byte not written");

  chk_cfg_layout: assert property (
    @(posedge REF_CLK) disable iff (RST)
    ar_take && page == PAGE_THIS && ar_idx == IDX_CONFIG
      |=> RVALID && RRESP == RESP_OKAY && RDATA[CFG_FIXED_ONE_BIT]
          && RDATA[31:8] == 24'h0)
    else $error("config byte read layout wrong");

  chk_page_gate: assert property (
    @(posedge REF_CLK) disable iff (RST)
    ar_take && page != PAGE_THIS && ar_idx != IDX_PAGE
      |=> RVALID && RRESP == RESP_SLVERR && RDATA == 32'h0)
    else $error("register reachable outside its page");

  chk_page_read: assert property (
    @(posedge REF_CLK) disable iff (RST)
    ar_take && ar_idx == IDX_PAGE
      |=> RVALID && RRESP == RESP_OKAY && RDATA[7:0] == $past(page))
    else $error("page register not readable");

endmodule

// file: age_tick_gen.sv
`timescale 1ns/10ps
module age_tick_gen
  import address_table_cfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [31:0] period,
  input  wire logic        speedup,
  output logic             tick
);

  logic [31:0] count;
  logic [31:0] gap;
  logic        clean;
  logic [31:0] last_period;
  logic        last_speedup;

  function automatic logic [31:0] eff_period(logic [31:0] p, logic s);
    logic [31:0] q;
    q = s ? (p >> AGE_SPEEDUP_SHIFT) : p;
    return (q == 32'h0) ? 32'h1 : q;
  endfunction

  // Compare with >= so a shortened period takes effect at once
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (count >= eff_period(period, speedup) - 32'h1) begin
      count <= 32'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end

  // Cycles since last tick, valid while settings stayed put
  always_ff @(posedge clk) begin
    if (rst) begin
      gap          <= 32'h0;
      clean        <= 1'b0;
      last_period  <= 32'h0;
      last_speedup <= 1'b0;
    end else begin
      gap          <= tick ? 32'h1 : gap + 32'h1;
      last_period  <= period;
      last_speedup <= speedup;
      if (tick)
        clean <= 1'b1;
      else if (period != last_period || speedup != last_speedup)
        clean <= 1'b0;
    end
  end

  chk_tick_spacing: assert property (
    @(posedge clk) disable iff (rst)
    tick && clean && $stable(period) && $stable(speedup)
      |-> gap == eff_period(period, speedup))
    else $error("aging tick spacing wrong");

  chk_speedup_rate: assert property (
    @(posedge clk) disable iff (rst)
    tick && clean && speedup && $stable(period) && $stable(speedup)
      && period >= 32'h100
      |-> gap == (period >> AGE_SPEEDUP_SHIFT))
    else $error("accelerated aging not period over 128");

  chk_normal_rate: assert property (
    @(posedge clk) disable iff (rst)
    tick && clean && !speedup && $stable(period) && $stable(speedup)
      && period != 32'h0
      |-> gap == period)
    else $error("normal aging not at full period");

endmodule

// file: tb.sv
`timescale 1ns/10ps
module tb
  import address_table_cfg_pkg::*;
;
  localparam logic [31:0] SIM_PERIOD = 32'd300;

  logic                  REF_CLK;
  logic                  RST;
  logic [ADDR_WIDTH-1:0] AWADDR;
  logic                  AWVALID;
  logic                  AWREADY;
  logic [DATA_WIDTH-1:0] WDATA;
  logic [STRB_WIDTH-1:0] WSTRB;
  logic                  WVALID;
  logic                  WREADY;
  logic [1:0]            BRESP;
  logic                  BVALID;
  logic                  BREADY;
  logic [ADDR_WIDTH-1:0] ARADDR;
  logic                  ARVALID;
  logic                  ARREADY;
  logic [DATA_WIDTH-1:0] RDATA;
  logic [1:0]            RRESP;
  logic                  RVALID;
  logic                  RREADY;
  logic                  FRAME_DA_VALID;
  logic [47:0]           FRAME_DA;
  logic                  TRAP_VALID;
  logic                  TRAP_HIT;
  logic                  AGE_TICK;
  logic                  AGE_SPEEDUP;
  logic                  HASH_BYPASS;
  int                    bad_count;
  int                    checks_done;

  address_table_global_config #(.AGE_PERIOD(SIM_PERIOD)) i_dut (
    .REF_CLK(REF_CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .FRAME_DA_VALID(FRAME_DA_VALID), .FRAME_DA(FRAME_DA),
    .TRAP_VALID(TRAP_VALID), .TRAP_HIT(TRAP_HIT), .AGE_TICK(AGE_TICK),
    .AGE_SPEEDUP(AGE_SPEEDUP), .HASH_BYPASS(HASH_BYPASS)
  );

  initial begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Both channels offered together; each released when taken
  // Waits for the answer; only the watchdog ends a stuck transfer
  task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                    output logic [1:0] resp);
    AWADDR  <= {idx, 2'b00};
    WDATA   <= d;
    WSTRB   <= 4'hf;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    resp = 2'bxx;
    forever begin
      @(posedge REF_CLK);
      if (AWVALID && AWREADY)
        AWVALID <= 1'b0;
      if (WVALID && WREADY)
        WVALID <= 1'b0;
      if (BVALID) begin
        resp = BRESP;
        break;
      end
    end
    BREADY <= 1'b0;
    @(posedge REF_CLK);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                    output logic [1:0] resp);
    ARADDR  <= {idx, 2'b00};
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    resp = 2'bxx;
    d = 'x;
    forever begin
      @(posedge REF_CLK);
      if (ARVALID && ARREADY)
        ARVALID <= 1'b0;
      if (RVALID) begin
        resp = RRESP;
        d = RDATA;
        break;
      end
    end
    RREADY <= 1'b0;
    @(posedge REF_CLK);
  endtask

  // Two frames back to back, results one cycle behind each
  task automatic frames(input logic [47:0] a, input logic [47:0] b,
                        input logic ha, input logic hb);
    FRAME_DA       <= a;
    FRAME_DA_VALID <= 1'b1;
    @(posedge REF_CLK);
    FRAME_DA       <= b;
    @(posedge REF_CLK);
    FRAME_DA_VALID <= 1'b0;
    FRAME_DA       <= ~b;
    check(TRAP_VALID, 1'b1, "first result");
    check(TRAP_HIT, ha, "first hit");
    @(posedge REF_CLK);
    check(TRAP_VALID, 1'b1, "second result");
    check(TRAP_HIT, hb, "second hit");
    @(posedge REF_CLK);
    check(TRAP_VALID, 1'b0, "result pulse");
  endtask

  // Gap taken between two later ticks; the first may be a leftover
  task automatic tick_gap(output int n);
    int k;
    for (k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge REF_CLK);
        n++;
      end while (AGE_TICK !== 1'b1 && n < 1000);
    end
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (AGE_TICK !== 1'b1 && n < 1000);
  endtask

  task automatic reset_values;
    logic [31:0] d;
    logic [1:0]  r;
    check(HASH_BYPASS, 1'b0, "bypass after reset");
    check(AGE_SPEEDUP, 1'b0, "speedup after reset");
    rd(IDX_CONFIG, d, r);
    check(r, RESP_SLVERR, "config off page");
    check(d, 32'h0, "config off page data");
    rd(IDX_PAGE, d, r);
    check(d, 32'(PAGE_RESET), "page reset");
    wr(IDX_PAGE, 32'(PAGE_THIS), r);
    check(r, RESP_OKAY, "page write");
    rd(IDX_CONFIG, d, r);
    check(d, 32'(CFG_RESET), "config reset");
    for (int k = 0; k < TRAP_BYTES; k++) begin
      rd(IDX_TRAP_FIRST + 8'(k), d, r);
      check(d, 32'(TRAP_RESET[8*k +: 8]), "trap byte reset");
    end
  endtask

  task automatic config_and_aging;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wr(IDX_CONFIG, 32'hff, r);
    rd(IDX_CONFIG, d, r);
    check(d, 32'h07, "config all set");
    check(HASH_BYPASS, 1'b1, "bypass set");
    check(AGE_SPEEDUP, 1'b1, "speedup set");
    tick_gap(n);
    check(n, 48'(SIM_PERIOD >> 7), "fast tick gap");
    wr(IDX_CONFIG, 32'h00, r);
    rd(IDX_CONFIG, d, r);
    check(d, 32'(CFG_RESET), "config cleared");
    check(HASH_BYPASS, 1'b0, "bypass clear");
    check(AGE_SPEEDUP, 1'b0, "speedup clear");
    tick_gap(n);
    check(n, 48'(SIM_PERIOD), "normal tick gap");
  endtask

  task automatic trap_rewrite;
    logic [47:0] fresh;
    logic [31:0] d;
    logic [1:0]  r;
    fresh = 48'h02a1b2c3d4e5;
    frames(TRAP_RESET, TRAP_RESET ^ 48'h1, 1'b1, 1'b0);
    for (int k = 0; k < TRAP_BYTES; k++)
      wr(IDX_TRAP_FIRST + 8'(k), 32'(fresh[8*k +: 8]), r);
    rd(IDX_TRAP_LAST, d, r);
    check(d, 32'(fresh[47:40]), "trap top byte");
    frames(fresh, TRAP_RESET, 1'b1, 1'b0);
  endtask

  // Two frames above matched; the counter must ignore writes
  task automatic own_regs;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    rd(IDX_TRAP_COUNT, d, r);
    check(d, 32'h2, "trap hits counted");
    wr(IDX_TRAP_COUNT, 32'h0, r);
    check(r, RESP_OKAY, "counter write answer");
    rd(IDX_TRAP_COUNT, d, r);
    check(d, 32'h2, "counter read only");
    wr(IDX_AGE_PERIOD, 32'd40, r);
    rd(IDX_AGE_PERIOD, d, r);
    check(d, 32'd40, "aging interval");
    tick_gap(n);
    check(n, 48'd40, "new tick gap");
  endtask

  task automatic refusals;
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h0a, 32'h5a, r);
    check(r, RESP_SLVERR, "reserved write");
    rd(8'h0a, d, r);
    check(r, RESP_SLVERR, "reserved read");
    wr(IDX_PAGE, 32'h03, r);
    wr(IDX_CONFIG, 32'h05, r);
    check(r, RESP_SLVERR, "config write off page");
    wr(IDX_PAGE, 32'(PAGE_THIS), r);
    rd(IDX_CONFIG, d, r);
    check(d, 32'(CFG_RESET), "config untouched");
  endtask

  initial begin
    bad_count = 0;
    checks_done = 0;
    RST = 1'b1;
    AWADDR = '0;
    AWVALID = 1'b0;
    WDATA = '0;
    WSTRB = '0;
    WVALID = 1'b0;
    BREADY = 1'b0;
    ARADDR = '0;
    ARVALID = 1'b0;
    RREADY = 1'b0;
    FRAME_DA_VALID = 1'b0;
    FRAME_DA = '0;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    reset_values();
    config_and_aging();
    trap_rewrite();
    own_regs();
    refusals();
    results();
  end

  // Whole run needs about twelve hundred cycles
  initial begin
    repeat (20000) @(posedge REF_CLK);
    bad_count++;
    $display("wrong value at %0t: run did not finish", $time);
    results();
  end
endmodule

// file: trap_match.sv
`timescale 1ns/10ps
module trap_match
  import address_table_cfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        da_valid,
  input  wire logic [47:0] da,
  input  wire logic [47:0] trap_address,
  output logic             result_valid,
  output logic             hit
);

  always_ff @(posedge clk) begin
    if (rst) begin
      result_valid <= 1'b0;
      hit          <= 1'b0;
    end else begin
      result_valid <= da_valid;
      hit          <= da_valid && (da == trap_address);
    end
  end

  chk_trap_hit: assert property (
    @(posedge clk) disable iff (rst)
    da_valid && da == trap_address |=> result_valid && hit)
    else $error("matching frame not trapped");

  chk_trap_miss: assert property (
    @(posedge clk) disable iff (rst)
    da_valid && da != trap_address |=> result_valid && !hit)
    else $error("non-matching frame trapped");

endmodule
